// ===== rtl/csi_pkg.sv
// constants and shared types for the core system integration block
package csi_pkg;
	localparam int CSI_NUM_IRQ = 32;
	localparam int CSI_NUM_WATCH = 2;
	localparam int CSI_NUM_BREAK = 4;
	localparam logic CSI_HALT_DEBUG = 1'b1;
	localparam logic CSI_SYSTEM_TICK_TIMER_PRESENT = 1'b1;
	localparam logic CSI_LITTLE_ENDIAN = 1'b1;

	localparam int CSI_CLK_NS = 10;
	localparam int CSI_SYSRST_NS = 80;
	localparam int CSI_SYSRST_CYC = (CSI_SYSRST_NS + CSI_CLK_NS - 1) / CSI_CLK_NS;

	localparam logic [31:0] CSI_ROM_BASE = 32'h0000_0000;
	localparam logic [31:0] CSI_RAM_BASE = 32'h2000_0000;
	localparam logic [31:0] CSI_RAM_ALIAS = 32'h2200_0000;
	localparam logic [31:0] CSI_SFR_BASE = 32'h4000_0000;
	localparam logic [31:0] CSI_SFR_ALIAS = 32'h4200_0000;
	localparam logic [31:0] CSI_CPU_BASE = 32'hE000_0000;
	localparam logic [31:0] CSI_CPU_LAST = 32'hE00F_FFFF;
	localparam logic [31:0] CSI_ALIAS_SPAN = 32'h0200_0000;

	localparam logic [31:0] CSI_ROM_SIZE_DEF = 32'h0002_0000;
	localparam logic [31:0] CSI_RAM_SIZE_DEF = 32'h0000_4000;
	localparam logic [31:0] CSI_SFR_SIZE_DEF = 32'h0010_0000;

	localparam logic [31:0] CSI_RDATA_RST = 32'h0000_0000;
	localparam logic [31:0] CSI_IRQ_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		CSI_SEL_ROM,
		CSI_SEL_RAM,
		CSI_SEL_SFR
	} csi_sel_t;

	typedef enum logic [1:0] {
		CSI_SZ_BYTE,
		CSI_SZ_HALF,
		CSI_SZ_WORD
	} csi_size_t;
endpackage

// ===== rtl/csi_if.sv
// internal carriers between the integration top and its helpers
`timescale 1ns/100ps
`default_nettype none

interface csi_mul_if;
	logic start;
	logic [31:0] op_a;
	logic [31:0] op_b;
	logic done;
	logic [31:0] prod;
	modport mst (output start, output op_a, output op_b, input done, input prod);
	modport slv (input start, input op_a, input op_b, output done, output prod);
endinterface

interface csi_bb_if;
	logic [31:0] addr;
	logic hit;
	logic [31:0] word_addr;
	logic [4:0] bit_idx;
	modport usr (output addr, input hit, input word_addr, input bit_idx);
	modport xl (input addr, output hit, output word_addr, output bit_idx);
endinterface

`default_nettype wire

// ===== rtl/csi_fast_mul.sv
// single-cycle multiplier keeping the low word of the product
`timescale 1ns/100ps
`default_nettype none

module csi_fast_mul
	import csi_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	csi_mul_if.slv m
);
	typedef struct packed {
		logic done;
		logic [31:0] prod;
	} csi_mul_state_t;

	csi_mul_state_t s_q;
	csi_mul_state_t s_d;
	logic [63:0] full;

	always_comb begin
		full = 64'(m.op_a) * 64'(m.op_b);
		s_d = s_q;
		s_d.done = m.start;
		if (m.start) begin
			s_d.prod = full[31:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign m.done = s_q.done;
	assign m.prod = s_q.prod;

	chk_mul_low_word: assert property (@(posedge core_clk) disable iff (reset)
		m.start |=> m.done && (64'(m.prod) == ((64'($past(m.op_a)) * 64'($past(m.op_b))) & 64'h0000_0000_FFFF_FFFF)))
		else $error("multiplier low word wrong");
endmodule

`default_nettype wire

// ===== rtl/csi_bitband.sv
// bit-band alias translation for one aliased region
`timescale 1ns/100ps
`default_nettype none

module csi_bitband
	import csi_pkg::*;
#(
	parameter logic [31:0] ALIAS_BASE = CSI_RAM_ALIAS,
	parameter logic [31:0] REAL_BASE = CSI_RAM_BASE,
	parameter logic [31:0] REAL_SIZE = CSI_RAM_SIZE_DEF
) (
	csi_bb_if.xl b
);
	logic [31:0] off;
	logic [31:0] byte_off;

	always_comb begin
		off = b.addr - ALIAS_BASE;
		byte_off = {5'h00, off[31:5]};
		// each alias word stands for one bit of the real region
		b.hit = (b.addr >= ALIAS_BASE) && (off < CSI_ALIAS_SPAN) && (byte_off < REAL_SIZE);
		b.word_addr = REAL_BASE + {12'h000, off[24:7], 2'b00};
		b.bit_idx = off[6:2];
	end
endmodule

`default_nettype wire

// ===== rtl/csi_top.sv
// processor core system integration: irq, reset request, sleep, multiplier, address decode
// Functional notes
// - exactly 32 interrupt request lines reach the core
// - fast 32x32 multiply returns only the low 32 product bits
// - system tick timer is present and may raise its exception
// - two watchpoints, four breakpoints, halting debug present
// - core raises its reset request when software sets the request bit
// - a core reset request causes the ordinary system reset
// - reset request is ignored while in low-speed mode
// - core raises a stall indicator on an unrecoverable exception
// - stall indicator is left unconnected; leave by NMI or reset
// - event lines unused; event input to core held low
// - core sleep indication on wait-for-interrupt, wait-for-event, handler exit
// - deep-sleep indication ignored; software keeps it cleared
// - ROM in code region, RAM in SRAM region, registers in peripheral region
// - bit-band aliasing over all RAM and peripheral registers
// - access to a fault region answers with a hard fault
// - core register region spans E000_0000 to E00F_FFFF
`timescale 1ns/100ps
`default_nettype none

module csi_top
	import csi_pkg::*;
#(
	parameter logic [31:0] ROM_SIZE = CSI_ROM_SIZE_DEF,
	parameter logic [31:0] RAM_SIZE = CSI_RAM_SIZE_DEF,
	parameter logic [31:0] SFR_SIZE = CSI_SFR_SIZE_DEF
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [CSI_NUM_IRQ-1:0] irq_src,
	output logic [CSI_NUM_IRQ-1:0] irq_to_core,
	input wire logic system_reset_request,
	input wire logic slow_mode,
	output logic sys_reset_out,
	input wire logic low_power_indicator,
	output logic low_power_out,
	output logic event_to_core,
	output logic cfg_system_tick_timer_present,
	output logic [1:0] cfg_watch_count,
	output logic [2:0] cfg_break_count,
	output logic cfg_halt_debug,
	output logic cfg_little_endian,
	input wire logic mul_start,
	input wire logic [31:0] mul_op_a,
	input wire logic [31:0] mul_op_b,
	output logic mul_done,
	output logic [31:0] mul_result,
	input wire logic bus_valid,
	input wire logic [31:0] bus_addr,
	input wire logic bus_write,
	input wire csi_size_t bus_size,
	input wire logic [31:0] bus_wdata,
	output logic bus_done,
	output logic bus_fault,
	output logic [31:0] bus_rdata,
	output logic mem_valid,
	output csi_sel_t mem_sel,
	output logic [31:0] mem_addr,
	output logic mem_write,
	output logic [3:0] mem_be,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	typedef enum logic [1:0] {
		CSI_ST_IDLE,
		CSI_ST_ACCESS,
		CSI_ST_BB_WRITE
	} csi_state_enum_t;

	typedef struct packed {
		csi_state_enum_t st;
		logic [CSI_NUM_IRQ-1:0] irq;
		logic sysrst;
		logic [7:0] rst_cnt;
		logic lp;
		logic evt;
		logic system_tick_timer;
		logic [1:0] watch;
		logic [2:0] brk;
		logic halt;
		logic le;
		logic done;
		logic fault;
		logic [31:0] rdata;
		logic mvalid;
		csi_sel_t msel;
		logic [31:0] maddr;
		logic mwe;
		logic [3:0] mbe;
		logic [31:0] mwdata;
		logic bb;
		logic bb_we;
		logic bb_val;
		logic [4:0] bit_idx;
		logic [1:0] lane;
		csi_size_t size;
	} csi_state_t;

	csi_state_t s_q;
	csi_state_t s_d;

	csi_mul_if mul_c ();
	csi_bb_if bb_ram ();
	csi_bb_if bb_sfr ();

	assign mul_c.start = mul_start;
	assign mul_c.op_a = mul_op_a;
	assign mul_c.op_b = mul_op_b;
	assign bb_ram.addr = bus_addr;
	assign bb_sfr.addr = bus_addr;

	csi_fast_mul u_mul (
		.core_clk(core_clk),
		.reset(reset),
		.m(mul_c.slv)
	);

	csi_bitband #(
		.ALIAS_BASE(CSI_RAM_ALIAS),
		.REAL_BASE(CSI_RAM_BASE),
		.REAL_SIZE(RAM_SIZE)
	) u_bb_ram (
		.b(bb_ram.xl)
	);

	csi_bitband #(
		.ALIAS_BASE(CSI_SFR_ALIAS),
		.REAL_BASE(CSI_SFR_BASE),
		.REAL_SIZE(SFR_SIZE)
	) u_bb_sfr (
		.b(bb_sfr.xl)
	);

	logic take;
	logic hit_rom;
	logic hit_ram;
	logic hit_sfr;
	logic hit_cpu;
	logic hit_none;
	logic [31:0] shifted;
	logic [31:0] merged;

	always_comb begin
		take = (s_q.st == CSI_ST_IDLE) && bus_valid && !s_q.done;
		hit_rom = (bus_addr - CSI_ROM_BASE) < ROM_SIZE;
		hit_ram = (bus_addr >= CSI_RAM_BASE) && ((bus_addr - CSI_RAM_BASE) < RAM_SIZE);
		hit_sfr = (bus_addr >= CSI_SFR_BASE) && ((bus_addr - CSI_SFR_BASE) < SFR_SIZE);
		hit_cpu = (bus_addr >= CSI_CPU_BASE) && (bus_addr <= CSI_CPU_LAST);
		hit_none = !(hit_rom || hit_ram || hit_sfr || hit_cpu || bb_ram.hit || bb_sfr.hit);
		shifted = mem_rdata >> {s_q.lane, 3'b000};
		merged = mem_rdata;
		merged[s_q.bit_idx] = s_q.bb_val;

		s_d = s_q;
		s_d.done = 1'b0;
		s_d.fault = 1'b0;

		s_d.irq = irq_src;
		s_d.lp = low_power_indicator;
		// deep-sleep, stall and event-out lines of the core have no port here
		s_d.evt = 1'b0;
		s_d.system_tick_timer = CSI_SYSTEM_TICK_TIMER_PRESENT;
		s_d.watch = 2'(CSI_NUM_WATCH);
		s_d.brk = 3'(CSI_NUM_BREAK);
		s_d.halt = CSI_HALT_DEBUG;
		s_d.le = CSI_LITTLE_ENDIAN;

		// reset request stretched to a full system reset pulse
		if (s_q.rst_cnt != 8'h00) begin
			s_d.rst_cnt = s_q.rst_cnt - 8'h01;
		end else if (system_reset_request && !slow_mode) begin
			s_d.rst_cnt = 8'(CSI_SYSRST_CYC);
		end
		s_d.sysrst = (s_d.rst_cnt != 8'h00);

		case (s_q.st)
			CSI_ST_IDLE: begin
				if (take) begin
					s_d.size = bus_size;
					s_d.lane = bus_addr[1:0];
					s_d.bb = 1'b0;
					if (hit_none) begin
						s_d.done = 1'b1;
						s_d.fault = 1'b1;
						s_d.rdata = CSI_RDATA_RST;
					end else if (hit_cpu) begin
						// core-private registers are served inside the core
						s_d.done = 1'b1;
						s_d.rdata = CSI_RDATA_RST;
					end else if (bb_ram.hit || bb_sfr.hit) begin
						s_d.bb = 1'b1;
						s_d.bb_we = bus_write;
						s_d.bb_val = bus_wdata[0];
						s_d.bit_idx = bb_ram.hit ? bb_ram.bit_idx : bb_sfr.bit_idx;
						s_d.maddr = bb_ram.hit ? bb_ram.word_addr : bb_sfr.word_addr;
						s_d.msel = bb_ram.hit ? CSI_SEL_RAM : CSI_SEL_SFR;
						s_d.mvalid = 1'b1;
						s_d.mwe = 1'b0;
						s_d.mbe = 4'hF;
						s_d.st = CSI_ST_ACCESS;
					end else begin
						s_d.msel = hit_rom ? CSI_SEL_ROM : (hit_ram ? CSI_SEL_RAM : CSI_SEL_SFR);
						s_d.maddr = {bus_addr[31:2], 2'b00};
						s_d.mvalid = 1'b1;
						s_d.mwe = bus_write;
						case (bus_size)
							CSI_SZ_BYTE: begin
								s_d.mbe = 4'h1 << bus_addr[1:0];
								s_d.mwdata = {4{bus_wdata[7:0]}};
							end
							CSI_SZ_HALF: begin
								s_d.mbe = bus_addr[1] ? 4'hC : 4'h3;
								s_d.mwdata = {2{bus_wdata[15:0]}};
							end
							default: begin
								s_d.mbe = 4'hF;
								s_d.mwdata = bus_wdata;
							end
						endcase
						s_d.st = CSI_ST_ACCESS;
					end
				end
			end
			CSI_ST_ACCESS: begin
				if (mem_ack) begin
					if (s_q.bb && s_q.bb_we) begin
						// read-modify-write of the target word
						s_d.mwe = 1'b1;
						s_d.mwdata = merged;
						s_d.st = CSI_ST_BB_WRITE;
					end else begin
						s_d.mvalid = 1'b0;
						s_d.done = 1'b1;
						s_d.st = CSI_ST_IDLE;
						if (s_q.bb) begin
							s_d.rdata = {31'h0000_0000, mem_rdata[s_q.bit_idx]};
						end else begin
							case (s_q.size)
								CSI_SZ_BYTE: s_d.rdata = {24'h00_0000, shifted[7:0]};
								CSI_SZ_HALF: s_d.rdata = {16'h0000, shifted[15:0]};
								default: s_d.rdata = mem_rdata;
							endcase
						end
					end
				end
			end
			CSI_ST_BB_WRITE: begin
				if (mem_ack) begin
					s_d.mvalid = 1'b0;
					s_d.done = 1'b1;
					s_d.rdata = CSI_RDATA_RST;
					s_d.st = CSI_ST_IDLE;
				end
			end
			default: begin
				s_d.st = CSI_ST_IDLE;
				s_d.mvalid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.st <= CSI_ST_IDLE;
			s_q.irq <= CSI_IRQ_RST;
			s_q.rdata <= CSI_RDATA_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign irq_to_core = s_q.irq;
	assign sys_reset_out = s_q.sysrst;
	assign low_power_out = s_q.lp;
	assign event_to_core = s_q.evt;
	assign cfg_system_tick_timer_present = s_q.system_tick_timer;
	assign cfg_watch_count = s_q.watch;
	assign cfg_break_count = s_q.brk;
	assign cfg_halt_debug = s_q.halt;
	assign cfg_little_endian = s_q.le;
	assign mul_done = mul_c.done;
	assign mul_result = mul_c.prod;
	assign bus_done = s_q.done;
	assign bus_fault = s_q.fault;
	assign bus_rdata = s_q.rdata;
	assign mem_valid = s_q.mvalid;
	assign mem_sel = s_q.msel;
	assign mem_addr = s_q.maddr;
	assign mem_write = s_q.mwe;
	assign mem_be = s_q.mbe;
	assign mem_wdata = s_q.mwdata;

	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset);

	chk_irq_follow_source: assert property (##1 irq_to_core == $past(irq_src))
		else $error("interrupt lines not passed to core");

	chk_reset_request_start: assert property (
		system_reset_request && !slow_mode && s_q.rst_cnt == 8'h00 |=> sys_reset_out)
		else $error("reset request did not start system reset");

	chk_reset_pulse_length: assert property ($rose(sys_reset_out) |-> sys_reset_out[*8] ##1 !sys_reset_out)
		else $error("system reset pulse length wrong");

	chk_reset_slow_block: assert property (slow_mode && s_q.rst_cnt == 8'h00 |=> !sys_reset_out)
		else $error("reset request acted in slow mode");

	chk_event_held_low: assert property (!event_to_core)
		else $error("event input to core driven");

	chk_sleep_follow: assert property (##1 low_power_out == $past(low_power_indicator))
		else $error("sleep indication not passed on");

	chk_fault_region_hit: assert property (take && hit_none |=> bus_done && bus_fault && !mem_valid)
		else $error("fault region did not fault");

	chk_cpu_region_ok: assert property (take && hit_cpu |=> bus_done && !bus_fault)
		else $error("core register region mishandled");

	chk_rom_select_range: assert property (take && hit_rom |=> mem_valid && mem_sel == CSI_SEL_ROM)
		else $error("ROM address not routed to ROM");

	chk_bitband_read_bit: assert property (bus_done && s_q.bb && !s_q.bb_we |-> bus_rdata[31:1] == 31'h0000_0000)
		else $error("bit-band read returned more than one bit");

	chk_bitband_rmw_write: assert property (
		s_q.st == CSI_ST_ACCESS && mem_ack && s_q.bb && s_q.bb_we |=> mem_valid && mem_write && mem_be == 4'hF)
		else $error("bit-band write did not follow its read");

	chk_half_lane_le: assert property (
		take && !hit_none && !hit_cpu && !bb_ram.hit && !bb_sfr.hit && bus_size == CSI_SZ_HALF
		|=> mem_be == ($past(bus_addr[1]) ? 4'hC : 4'h3))
		else $error("half-word lanes not little-endian");

	chk_byte_lane_le: assert property (
		take && !hit_none && !hit_cpu && !bb_ram.hit && !bb_sfr.hit && bus_size == CSI_SZ_BYTE
		|=> mem_be == (4'h1 << $past(bus_addr[1:0])))
		else $error("byte lane not little-endian");
endmodule

`default_nettype wire

// ===== dv/csi_mem_model.sv
// memory partner answering the memory port of the integration block
`timescale 1ns/100ps
`default_nettype none
module csi_mem_model (
	input wire logic core_clk,
	input wire logic [1:0] dly,
	input wire logic mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic mem_write,
	input wire logic [3:0] mem_be,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [256];
	logic [1:0] wait_q;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0000_0000;
		wait_q = 2'h0;
		foreach (mem[i]) mem[i] = 32'h0000_0000;
	end
	always @(posedge core_clk) begin
		// stale data changes every cycle
		mem_rdata <= ~mem_rdata;
		if (mem_ack || !mem_valid) begin
			mem_ack <= 1'b0;
			wait_q <= 2'h0;
		end else if (wait_q != dly) begin
			wait_q <= wait_q + 2'h1;
		end else begin
			mem_ack <= 1'b1;
			for (int i = 0; i < 4; i++) begin
				if (mem_write && mem_be[i]) mem[mem_addr[9:2]][8*i+:8] <= mem_wdata[8*i+:8];
			end
			mem_rdata <= mem[mem_addr[9:2]];
		end
	end
endmodule
`default_nettype wire

// ===== dv/tb_core_system_integration.sv
// self-checking bench for the core system integration block
`timescale 1ns/100ps
`default_nettype none
module tb_core_system_integration
	import csi_pkg::*;
;
	logic core_clk, reset, system_reset_request, slow_mode, low_power_indicator, low_power_out;
	logic [31:0] irq_src, irq_to_core, mul_op_a, mul_op_b, mul_result, bus_addr, bus_wdata, bus_rdata;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, rd;
	logic sys_reset_out, event_to_core, cfg_system_tick_timer_present, cfg_halt_debug, cfg_little_endian;
	logic [1:0] cfg_watch_count, dly;
	logic [2:0] cfg_break_count;
	logic mul_start, mul_done, bus_valid, bus_write, bus_done, bus_fault, flt, memseen;
	logic mem_valid, mem_write, mem_ack;
	logic [3:0] mem_be;
	csi_size_t bus_size;
	csi_sel_t mem_sel, sel_seen;
	int error_cnt = 0;
	int compares = 0;

	csi_top dut (.core_clk(core_clk), .reset(reset), .irq_src(irq_src), .irq_to_core(irq_to_core),
		.system_reset_request(system_reset_request), .slow_mode(slow_mode), .sys_reset_out(sys_reset_out),
		.low_power_indicator(low_power_indicator), .low_power_out(low_power_out), .event_to_core(event_to_core),
		.cfg_system_tick_timer_present(cfg_system_tick_timer_present), .cfg_watch_count(cfg_watch_count),
		.cfg_break_count(cfg_break_count), .cfg_halt_debug(cfg_halt_debug), .cfg_little_endian(cfg_little_endian),
		.mul_start(mul_start), .mul_op_a(mul_op_a), .mul_op_b(mul_op_b), .mul_done(mul_done),
		.mul_result(mul_result), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_write(bus_write),
		.bus_size(bus_size), .bus_wdata(bus_wdata), .bus_done(bus_done), .bus_fault(bus_fault),
		.bus_rdata(bus_rdata), .mem_valid(mem_valid), .mem_sel(mem_sel), .mem_addr(mem_addr),
		.mem_write(mem_write), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	csi_mem_model mem (.core_clk(core_clk), .dly(dly), .mem_valid(mem_valid), .mem_addr(mem_addr),
		.mem_write(mem_write), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	always #5 core_clk = ~core_clk;

	task automatic test_done();
		if (error_cnt == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// one bus transfer, entered and left at a falling edge
	task automatic bus(input logic [31:0] a, input logic w, input csi_size_t sz, input logic [31:0] wd);
		int n;
		n = 0;
		memseen = 1'b0;
		bus_valid = 1'b1;
		bus_addr = a;
		bus_write = w;
		bus_size = sz;
		bus_wdata = wd;
		do begin
			@(negedge core_clk);
			n++;
			if (mem_valid === 1'b1) begin
				memseen = 1'b1;
				sel_seen = mem_sel;
			end
		end while (bus_done !== 1'b1 && n < 50);
		rd = bus_rdata;
		flt = bus_fault;
		bus_valid = 1'b0;
		// let an edge pass so a following call never re-raises valid in this time step
		@(negedge core_clk);
		if (n >= 50) cmp(32'h0, 32'h1, "bus timeout");
	endtask

	task automatic t_cfg();
		cmp({27'h0, cfg_system_tick_timer_present, cfg_halt_debug, cfg_little_endian, event_to_core, 1'b0}, 32'h1C, "flags");
		cmp({28'h0, cfg_watch_count, 2'h0}, 32'h8, "watch");
		cmp({29'h0, cfg_break_count}, 32'h4, "break");
	endtask

	task automatic t_pass();
		irq_src = 32'hA5F0_0F5A;
		low_power_indicator = 1'b1;
		@(negedge core_clk);
		cmp(irq_to_core, 32'hA5F0_0F5A, "irq");
		cmp({31'h0, low_power_out}, 32'h1, "sleep");
		irq_src = 32'h5A0F_F0A5;
		low_power_indicator = 1'b0;
		@(negedge core_clk);
		cmp(irq_to_core, 32'h5A0F_F0A5, "irq");
		cmp({31'h0, low_power_out}, 32'h0, "sleep");
	endtask

	task automatic t_mul();
		logic [31:0] ma [3] = '{32'hFFFF_FFFF, 32'h1234_5678, 32'h0001_0000};
		logic [31:0] mb [3] = '{32'hFFFF_FFFF, 32'h9ABC_DEF0, 32'h0001_0000};
		mul_start = 1'b1;
		for (int i = 0; i < 3; i++) begin
			mul_op_a = ma[i];
			mul_op_b = mb[i];
			@(negedge core_clk);
			cmp({31'h0, mul_done}, 32'h1, "mul done");
			cmp(mul_result, ma[i] * mb[i], "mul low word");
		end
		mul_start = 1'b0;
	endtask

	task automatic t_rst();
		system_reset_request = 1'b1;
		@(negedge core_clk);
		system_reset_request = 1'b0;
		for (int i = 0; i < 8; i++) begin
			cmp({31'h0, sys_reset_out}, 32'h1, "reset pulse");
			@(negedge core_clk);
		end
		cmp({31'h0, sys_reset_out}, 32'h0, "reset end");
		slow_mode = 1'b1;
		system_reset_request = 1'b1;
		repeat (3) begin
			@(negedge core_clk);
			cmp({31'h0, sys_reset_out}, 32'h0, "slow reset");
		end
		system_reset_request = 1'b0;
		slow_mode = 1'b0;
	endtask

	task automatic t_lanes();
		bus(32'h2000_0010, 1'b1, CSI_SZ_WORD, 32'h8877_6655);
		cmp({30'h0, sel_seen}, {30'h0, CSI_SEL_RAM}, "ram sel");
		bus(32'h2000_0011, 1'b1, CSI_SZ_BYTE, 32'h0000_00AB);
		bus(32'h2000_0013, 1'b0, CSI_SZ_BYTE, 32'h0);
		cmp(rd, 32'h0000_0088, "byte lane");
		bus(32'h2000_0012, 1'b0, CSI_SZ_HALF, 32'h0);
		cmp(rd, 32'h0000_8877, "half lane");
		bus(32'h2000_0010, 1'b0, CSI_SZ_WORD, 32'h0);
		cmp(rd, 32'h8877_AB55, "merged word");
		bus(32'h2000_0016, 1'b1, CSI_SZ_HALF, 32'h1234_CDEF);
		bus(32'h2000_0014, 1'b0, CSI_SZ_WORD, 32'h0);
		cmp(rd, 32'hCDEF_0000, "half write lane");
		bus(32'h0000_0020, 1'b0, CSI_SZ_WORD, 32'h0);
		cmp({30'h0, sel_seen}, {30'h0, CSI_SEL_ROM}, "rom sel");
		bus(32'h4000_0000, 1'b1, CSI_SZ_WORD, 32'h0000_00F0);
		cmp({30'h0, sel_seen}, {30'h0, CSI_SEL_SFR}, "sfr sel");
	endtask

	task automatic t_bitband();
		dly = 2'h3;
		bus(32'h2200_0214, 1'b0, CSI_SZ_WORD, 32'h0);
		cmp(rd, 32'h0, "alias read");
		bus(32'h2200_0214, 1'b1, CSI_SZ_WORD, 32'h1);
		bus(32'h2000_0010, 1'b0, CSI_SZ_WORD, 32'h0);
		cmp(rd, 32'h8877_AB75, "alias set");
		bus(32'h2200_0214, 1'b0, CSI_SZ_WORD, 32'h0);
		cmp(rd, 32'h1, "alias read");
		bus(32'h4200_007C, 1'b1, CSI_SZ_WORD, 32'h1);
		bus(32'h4000_0000, 1'b0, CSI_SZ_WORD, 32'h0);
		cmp(rd, 32'h8000_00F0, "sfr alias set");
		dly = 2'h0;
	endtask

	task automatic t_regions();
		logic [31:0] ra [5] = '{32'h6000_0000, 32'hE010_0000, 32'h2000_4000, 32'hE000_0000, 32'hE00F_FFFC};
		logic rf [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 5; i++) begin
			bus(ra[i], 1'b0, CSI_SZ_WORD, 32'h0);
			cmp({31'h0, flt}, {31'h0, rf[i]}, "fault");
			cmp({31'h0, memseen}, 32'h0, "no memory access");
			if (!rf[i]) cmp(rd, 32'h0, "core region data");
		end
	endtask

	initial begin
		#50000;
		error_cnt++;
		test_done();
	end

	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		{system_reset_request, slow_mode, low_power_indicator, mul_start, bus_valid, bus_write} = 6'h0;
		{irq_src, mul_op_a, mul_op_b, bus_addr, bus_wdata} = '0;
		bus_size = CSI_SZ_WORD;
		dly = 2'h0;
		repeat (6) @(negedge core_clk);
		reset = 1'b0;
		repeat (2) @(negedge core_clk);
		t_cfg();
		t_pass();
		t_mul();
		t_rst();
		t_lanes();
		t_bitband();
		t_regions();
		test_done();
	end
endmodule
`default_nettype wire
